// ---- gst_pkg.sv ----
package gst_pkg;

  localparam int ADR_W = 4;
  localparam int DAT_W = 32;
  localparam int SEL_W = DAT_W / 8;
  localparam int BYTE_W = 8;

  localparam logic [ADR_W-1:0] OFS_COUNT_LOW = 4'h0;
  localparam logic [ADR_W-1:0] OFS_COUNT_HIGH = 4'h4;
  localparam logic [ADR_W-1:0] OFS_CONTROL = 4'h8;
  localparam logic [ADR_W-1:0] OFS_STATUS = 4'hC;

  localparam int OVF_BIT = 0;

  localparam int PRESC_W = 3;
  localparam int INSTR_DIV = 4;
  localparam int INSTR_W = 2;

  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
  localparam logic [7:0] BYTE_RST = 8'h00;

  typedef enum logic [1:0] {
    GST_SRC_INSTR,
    GST_SRC_FULL,
    GST_SRC_PIN,
    GST_SRC_RSVD
  } gst_src_t;

  typedef struct packed {
    logic [1:0] prescale_ratio;
    gst_src_t clock_source;
    logic sync_bypass;
    logic wide_access_mode;
    logic gate_polarity;
    logic gate_enable;
    logic on;
  } gst_ctrl_t;

  localparam int CTRL_W = $bits(gst_ctrl_t);
  localparam gst_ctrl_t CTRL_RST = '0;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [SEL_W-1:0] sel;
    logic [ADR_W-1:0] adr;
    logic [DAT_W-1:0] dat;
  } gst_wb_req_t;

endpackage : gst_pkg

// ---- gst_prescaler.sv ----
module gst_prescaler #(
  parameter int W = gst_pkg::PRESC_W
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic clear_i,
  input wire logic tick_i,
  input wire logic [1:0] ratio_i,
  output logic tick_o
);

  logic [W-1:0] cnt_ff;
  logic [W-1:0] nxt_cnt;
  logic [W-1:0] mask;

  // divide by 2**ratio: a tick passes when all masked bits are set
  assign mask = ~({W{1'b1}} << ratio_i);
  assign tick_o = tick_i && ((cnt_ff & mask) == mask);

  always_comb begin
    nxt_cnt = cnt_ff;
    if (clear_i) begin
      nxt_cnt = '0; // [R07]
    end else if (tick_i) begin
      nxt_cnt = tick_o ? '0 : W'(cnt_ff + 1'b1); // [R06]
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_ff <= '0; // [R21]
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  AST_PRESC_CLEAR: assert property (@(posedge clk_i) disable iff (rst_i) // [R07]
    clear_i |=> cnt_ff == '0)
    else $error("prescale counter not cleared");

  AST_PRESC_DIV8: assert property (@(posedge clk_i) disable iff (rst_i) // [R06]
    (tick_o && ratio_i == 2'd3) |-> cnt_ff == 3'd7)
    else $error("divide by eight passed an early tick");

endmodule : gst_prescaler

// ---- gst_timer.sv ----
// Contract
// R01: sixteen-bit up-counter, byte writes replace count
// R02: on gates everything; gate enable adds gating
// R03: full-rate source gives four counts per instruction
// R04: external rising edge needs prior falling edge
// R05: external pin rising edges increment, sync optional
// R06: prescaler divides by 1, 2, 4, 8
// R07: count writes clear the prescale counter
// R08: wide mode high write keeps prescaler
// R09: bypass runs external clock unsynchronised, also sleeping
// R10: synchroniser stops in sleep
// R11: mode switch may skip or add one
// R12: each byte read returns coherent value
// R13: software stops timer before asynchronous writes
// R14: wide mode high byte goes via buffer
// R15: low read snapshots high byte into buffer
// R16: low write loads buffer and low together
// R17: gate inactive holds count
// R18: polarity selects active gate level
// R19: no synced comparator with synced clock
// R20: wrap to zero sets sticky overflow flag
// R21: reset clears counts, buffer, prescaler, controls
module gst_timer (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire gst_pkg::gst_wb_req_t wb_i,
  output logic [gst_pkg::DAT_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic external_count_pin_i,
  input wire logic gate_input_i,
  input wire logic sleep_i,
  output logic overflow_flag_o
);

  function automatic logic [gst_pkg::DAT_W-1:0] merge_bytes(
    input logic [gst_pkg::DAT_W-1:0] old_val,
    input logic [gst_pkg::DAT_W-1:0] new_val,
    input logic [gst_pkg::SEL_W-1:0] sel
  );
    logic [gst_pkg::DAT_W-1:0] res;
    res = old_val;
    for (int i = 0; i < gst_pkg::SEL_W; i++) begin
      if (sel[i]) begin
        res[i*gst_pkg::BYTE_W +: gst_pkg::BYTE_W] = new_val[i*gst_pkg::BYTE_W +: gst_pkg::BYTE_W];
      end
    end
    return res;
  endfunction : merge_bytes

  // bus slave state
  logic ack_ff;
  logic nxt_ack;
  logic [gst_pkg::DAT_W-1:0] dat_ff;
  logic [gst_pkg::DAT_W-1:0] nxt_dat;

  // timer state
  logic [15:0] count_ff;
  logic [15:0] nxt_count;
  logic [7:0] high_buf_ff;
  logic [7:0] nxt_high_buf;
  gst_pkg::gst_ctrl_t ctrl_ff;
  gst_pkg::gst_ctrl_t nxt_ctrl;
  logic ovf_ff;
  logic nxt_ovf;
  logic armed_ff;
  logic nxt_armed;
  logic [gst_pkg::INSTR_W-1:0] instr_ff;
  logic [gst_pkg::INSTR_W-1:0] nxt_instr;

  // pin paths: synchronised chain and bypass sampler
  logic sync1_ff;
  logic sync2_ff;
  logic sync3_ff;
  logic byp_ff;
  logic byp_prev_ff;
  logic [3:0] nxt_pins;

  logic acc;
  logic wr;
  logic rd;
  logic wr_low;
  logic wr_high;
  logic wr_ctrl;
  logic wr_stat;
  logic rd_low;
  logic wr_count;
  logic presc_clr;
  logic pin_rise;
  logic pin_fall;
  logic gate_active;
  logic cnt_en;
  logic src_tick;
  logic presc_tick;
  logic inc;
  logic [gst_pkg::DAT_W-1:0] wdat;

  // side effects happen at the edge where ack rises; master still holds the request
  assign acc = wb_i.cyc && wb_i.stb && !ack_ff;
  assign wr = acc && wb_i.we;
  assign rd = acc && !wb_i.we;
  assign wr_low = wr && wb_i.adr == gst_pkg::OFS_COUNT_LOW && wb_i.sel[0];
  assign wr_high = wr && wb_i.adr == gst_pkg::OFS_COUNT_HIGH && wb_i.sel[0];
  assign wr_ctrl = wr && wb_i.adr == gst_pkg::OFS_CONTROL;
  assign wr_stat = wr && wb_i.adr == gst_pkg::OFS_STATUS && wb_i.sel[0];
  assign rd_low = rd && wb_i.adr == gst_pkg::OFS_COUNT_LOW;
  assign wdat = wb_i.dat;

  // a buffered high write touches neither count nor prescaler
  assign wr_count = wr_low || (wr_high && !ctrl_ff.wide_access_mode); // [R01] [R14]
  assign presc_clr = wr_count; // [R07] [R08]

  // bypass path keeps sampling in sleep; the synchroniser chain is frozen
  assign pin_rise = ctrl_ff.sync_bypass ? (byp_ff && !byp_prev_ff)
                                        : (sync2_ff && !sync3_ff && !sleep_i); // [R05] [R09] [R10]
  assign pin_fall = ctrl_ff.sync_bypass ? (!byp_ff && byp_prev_ff)
                                        : (!sync2_ff && sync3_ff && !sleep_i);

  assign gate_active = gate_input_i == ctrl_ff.gate_polarity; // [R18]
  assign cnt_en = ctrl_ff.on && (!ctrl_ff.gate_enable || gate_active); // [R02] [R17]

  // switching sync_bypass mid-count may drop or add one edge; accepted [R11]
  always_comb begin
    src_tick = 1'b0;
    case (ctrl_ff.clock_source)
      gst_pkg::GST_SRC_INSTR: src_tick = !sleep_i && instr_ff == gst_pkg::INSTR_W'(gst_pkg::INSTR_DIV - 1);
      gst_pkg::GST_SRC_FULL: src_tick = !sleep_i; // [R03]
      gst_pkg::GST_SRC_PIN: src_tick = pin_rise && armed_ff; // [R04] [R05]
      default: src_tick = 1'b0;
    endcase
  end

  gst_prescaler #(
    .W(gst_pkg::PRESC_W)
  ) u_presc (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clear_i(presc_clr),
    .tick_i(src_tick && cnt_en),
    .ratio_i(ctrl_ff.prescale_ratio),
    .tick_o(presc_tick)
  );

  // a count write racing an increment wins; software should stop the timer first [R13]
  assign inc = presc_tick && !wr_count;

  always_comb begin
    nxt_instr = sleep_i ? instr_ff : gst_pkg::INSTR_W'(instr_ff + 1'b1);
    nxt_pins = {external_count_pin_i, sync1_ff, sync2_ff, byp_ff};
  end

  always_comb begin
    nxt_count = count_ff;
    nxt_high_buf = high_buf_ff;
    nxt_ctrl = ctrl_ff;
    nxt_ovf = ovf_ff;
    nxt_armed = armed_ff;
    if (inc) begin
      nxt_count = 16'(count_ff + 1'b1); // [R01]
    end
    if (ctrl_ff.wide_access_mode) begin
      if (wr_high) begin
        nxt_high_buf = wdat[7:0]; // [R14]
      end
      if (rd_low) begin
        nxt_high_buf = count_ff[15:8]; // [R15]
      end
      if (wr_low) begin
        nxt_count = {high_buf_ff, wdat[7:0]}; // [R16]
      end
    end else begin
      if (wr_low) begin
        nxt_count[7:0] = wdat[7:0]; // [R01]
      end
      if (wr_high) begin
        nxt_count[15:8] = wdat[7:0]; // [R01]
      end
    end
    if (wr_ctrl) begin
      nxt_ctrl = gst_pkg::gst_ctrl_t'(gst_pkg::CTRL_W'(merge_bytes(
        gst_pkg::DAT_W'(ctrl_ff), wdat, wb_i.sel)));
    end
    if (wr_stat && wdat[gst_pkg::OVF_BIT]) begin
      nxt_ovf = 1'b0;
    end
    if (inc && count_ff == gst_pkg::COUNT_MAX) begin
      nxt_ovf = 1'b1; // [R20]
    end
    // rising edges only count once a falling edge has been seen
    if (wr_count || !ctrl_ff.on) begin
      nxt_armed = 1'b0; // [R04]
    end else if (pin_fall) begin
      nxt_armed = 1'b1; // [R04]
    end
  end

  always_comb begin
    nxt_ack = acc;
    nxt_dat = '0;
    if (rd) begin
      case (wb_i.adr)
        gst_pkg::OFS_COUNT_LOW: nxt_dat[7:0] = count_ff[7:0]; // [R12]
        gst_pkg::OFS_COUNT_HIGH: begin
          nxt_dat[7:0] = ctrl_ff.wide_access_mode ? high_buf_ff : count_ff[15:8]; // [R14] [R12]
        end
        gst_pkg::OFS_CONTROL: nxt_dat[gst_pkg::CTRL_W-1:0] = ctrl_ff;
        gst_pkg::OFS_STATUS: nxt_dat[gst_pkg::OVF_BIT] = ovf_ff;
        default: nxt_dat = '0;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
      dat_ff <= '0;
      count_ff <= gst_pkg::COUNT_RST; // [R21]
      high_buf_ff <= gst_pkg::BYTE_RST; // [R21]
      ctrl_ff <= gst_pkg::CTRL_RST; // [R21]
      ovf_ff <= 1'b0;
      armed_ff <= 1'b0;
      instr_ff <= '0;
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
      sync3_ff <= 1'b0;
      byp_ff <= 1'b0;
      byp_prev_ff <= 1'b0;
    end else begin
      ack_ff <= nxt_ack;
      dat_ff <= nxt_dat;
      count_ff <= nxt_count;
      high_buf_ff <= nxt_high_buf;
      ctrl_ff <= nxt_ctrl;
      ovf_ff <= nxt_ovf;
      armed_ff <= nxt_armed;
      instr_ff <= nxt_instr;
      if (!sleep_i) begin
        sync1_ff <= nxt_pins[3]; // [R10]
        sync2_ff <= nxt_pins[2];
        sync3_ff <= nxt_pins[1];
      end
      byp_ff <= external_count_pin_i; // [R09]
      byp_prev_ff <= nxt_pins[0];
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;
  assign overflow_flag_o = ovf_ff;

  AST_OFF_HOLDS: assert property (@(posedge clk_i) disable iff (rst_i) // [R02]
    (!ctrl_ff.on && !wr_count) |=> count_ff == $past(count_ff))
    else $error("count moved while timer off");

  AST_GATE_HOLDS: assert property (@(posedge clk_i) disable iff (rst_i) // [R17]
    (ctrl_ff.on && ctrl_ff.gate_enable && gate_input_i != ctrl_ff.gate_polarity && !wr_count)
    |=> count_ff == $past(count_ff))
    else $error("count moved while gate inactive");

  AST_FULL_RATE: assert property (@(posedge clk_i) disable iff (rst_i) // [R03]
    (ctrl_ff.on && !ctrl_ff.gate_enable && ctrl_ff.clock_source == gst_pkg::GST_SRC_FULL
     && ctrl_ff.prescale_ratio == 2'd0 && !sleep_i && !wr_count && !wr_ctrl)
    |=> count_ff == 16'($past(count_ff) + 1'b1))
    else $error("full rate source did not count every clock");

  AST_SNAPSHOT: assert property (@(posedge clk_i) disable iff (rst_i) // [R15]
    (rd_low && ctrl_ff.wide_access_mode) |=> high_buf_ff == $past(count_ff[15:8]))
    else $error("low read did not snapshot high byte");

  AST_BUF_WRITE: assert property (@(posedge clk_i) disable iff (rst_i) // [R14] [R08]
    (wr_high && ctrl_ff.wide_access_mode)
    |-> !presc_clr ##1 high_buf_ff == $past(wdat[7:0]))
    else $error("buffered high write went astray");

  AST_WIDE_LOAD: assert property (@(posedge clk_i) disable iff (rst_i) // [R16]
    (wr_low && ctrl_ff.wide_access_mode) |=> count_ff == {$past(high_buf_ff), $past(wdat[7:0])})
    else $error("wide low write did not load both bytes");

  AST_WRAP_FLAG: assert property (@(posedge clk_i) disable iff (rst_i) // [R20]
    (inc && count_ff == gst_pkg::COUNT_MAX) |=> overflow_flag_o && count_ff == gst_pkg::COUNT_RST)
    else $error("wrap did not set overflow flag");

  AST_SLEEP_SYNC: assert property (@(posedge clk_i) disable iff (rst_i) // [R10]
    (sleep_i && !ctrl_ff.sync_bypass && !wr_count) |=> count_ff == $past(count_ff))
    else $error("synchronised path counted in sleep");

  AST_DISARM: assert property (@(posedge clk_i) disable iff (rst_i) // [R04]
    wr_count |=> !armed_ff)
    else $error("count write did not disarm edge detector");

  AST_RESET: assert property (@(posedge clk_i) // [R21]
    rst_i |=> count_ff == gst_pkg::COUNT_RST && ctrl_ff == gst_pkg::CTRL_RST && !wb_ack_o)
    else $error("reset values wrong");

  AST_GATE_COUNTS: assert property (@(posedge clk_i) disable iff (rst_i) // [R17] [R18]
    (ctrl_ff.on && ctrl_ff.gate_enable && gate_input_i == ctrl_ff.gate_polarity
     && ctrl_ff.clock_source == gst_pkg::GST_SRC_FULL && ctrl_ff.prescale_ratio == 2'd0
     && !sleep_i && !wr_count && !wr_ctrl)
    |=> count_ff == 16'($past(count_ff) + 1'b1))
    else $error("count held while gate active");

  AST_INSTR_RATE: assert property (@(posedge clk_i) disable iff (rst_i) // [R03]
    (inc && ctrl_ff.clock_source == gst_pkg::GST_SRC_INSTR)
    |=> (!inc || ctrl_ff.clock_source != gst_pkg::GST_SRC_INSTR) [*3])
    else $error("instruction clock source counted too fast");

  AST_PIN_UNARMED: assert property (@(posedge clk_i) disable iff (rst_i) // [R04]
    (ctrl_ff.clock_source == gst_pkg::GST_SRC_PIN && !armed_ff && !wr_count)
    |=> count_ff == $past(count_ff))
    else $error("pin edge counted before a falling edge");

  AST_NARROW_LOW: assert property (@(posedge clk_i) disable iff (rst_i) // [R01]
    (wr_low && !ctrl_ff.wide_access_mode)
    |=> count_ff[7:0] == $past(wdat[7:0]) && count_ff[15:8] == $past(count_ff[15:8]))
    else $error("low write did not replace low byte only");

  AST_NARROW_HIGH: assert property (@(posedge clk_i) disable iff (rst_i) // [R01] [R07]
    (wr_high && !ctrl_ff.wide_access_mode)
    |-> presc_clr ##1 count_ff[15:8] == $past(wdat[7:0]))
    else $error("direct high write went astray");

  AST_OVF_STICKY: assert property (@(posedge clk_i) disable iff (rst_i) // [R20]
    (overflow_flag_o && !(wr_stat && wdat[gst_pkg::OVF_BIT])) |=> overflow_flag_o)
    else $error("overflow flag dropped without a clear");

  AST_HIGH_READ: assert property (@(posedge clk_i) disable iff (rst_i) // [R14]
    (rd && wb_i.adr == gst_pkg::OFS_COUNT_HIGH && ctrl_ff.wide_access_mode)
    |=> wb_ack_o && wb_dat_o[7:0] == $past(high_buf_ff))
    else $error("wide high read did not return the buffer");

  AST_LOW_READ: assert property (@(posedge clk_i) disable iff (rst_i) // [R12]
    (rd && wb_i.adr == gst_pkg::OFS_COUNT_LOW)
    |=> wb_ack_o && wb_dat_o[7:0] == $past(count_ff[7:0]))
    else $error("low read returned a torn value");

  COV_WRAP: cover property (@(posedge clk_i) disable iff (rst_i)
    inc && count_ff == gst_pkg::COUNT_MAX);
  COV_WIDE_READ: cover property (@(posedge clk_i) disable iff (rst_i)
    rd_low && ctrl_ff.wide_access_mode);
  COV_GATED_PIN: cover property (@(posedge clk_i) disable iff (rst_i)
    inc && ctrl_ff.gate_enable && ctrl_ff.clock_source == gst_pkg::GST_SRC_PIN);
  COV_BYPASS_SLEEP: cover property (@(posedge clk_i) disable iff (rst_i)
    inc && sleep_i && ctrl_ff.sync_bypass);

endmodule : gst_timer

// ---- gst_pin_model.sv ----
// drives the count pin and the gate level from the far side of the timer
module gst_pin_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic go_i,
  input wire logic [7:0] n_i,
  input wire logic gate_level_i,
  output logic pin_o,
  output logic gate_o,
  output logic busy_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] left_ff;
  logic [2:0] ph_ff;
  logic pin_ff;
  // pin rests low between bursts; every pulse is four clocks low, four high
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      left_ff <= 8'h00;
      ph_ff <= 3'h0;
      pin_ff <= 1'b0;
    end else if (go_i && left_ff == 8'h00) begin
      left_ff <= n_i;
      ph_ff <= 3'h0;
    end else if (left_ff != 8'h00) begin
      ph_ff <= ph_ff + 3'h1;
      if (ph_ff == 3'h3) pin_ff <= 1'b1;
      if (ph_ff == 3'h7) begin
        pin_ff <= 1'b0;
        left_ff <= left_ff - 8'h01;
      end
    end
  end
  assign pin_o = pin_ff;
  assign busy_o = left_ff != 8'h00;
  // a plain gate level only, no synchronised comparator source
  assign gate_o = gate_level_i;
endmodule : gst_pin_model

// ---- tb_top.sv ----
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  gst_pkg::gst_wb_req_t wb = '0;
  logic [31:0] rd, v;
  logic ack, ovf, pin, gate, busy;
  logic go = 1'b0;
  logic gl = 1'b0;
  logic slp = 1'b0;
  logic [7:0] np = 8'h00;
  int n_fail = 0;
  int checked = 0;
  int cyc = 0;
  int e;
  always #12.5 clk_i = ~clk_i;
  gst_timer i_gst_timer (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb), .wb_dat_o(rd),
    .wb_ack_o(ack), .external_count_pin_i(pin), .gate_input_i(gate),
    .sleep_i(slp), .overflow_flag_o(ovf));
  gst_pin_model i_gst_pin_model (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .n_i(np),
    .gate_level_i(gl), .pin_o(pin), .gate_o(gate), .busy_o(busy));
  task automatic summarize;
    $display("checks %0d fails %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : summarize
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      summarize();
    end
  end
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
    checked++;
    if (s !== x) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, x, s);
    end
  endtask : chk
  // one increment either way is allowed for edge alignment at start and stop
  // an unknown seen value stays unknown so the compare still trips
  function automatic logic [31:0] near(input logic [31:0] s, input int x);
    logic [31:0] lo;
    logic [31:0] hi;
    lo = (x > 0) ? 32'(x - 1) : 32'h0000_0000;
    hi = 32'(x + 1);
    return (s >= lo && s <= hi) ? 32'(x) : s;
  endfunction : near
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clk_i);
    wb <= '{cyc: 1'b1, stb: 1'b1, we: w, sel: 4'hF, adr: a, dat: d};
    do @(posedge clk_i); while (ack !== 1'b1);
    q = rd;
    wb <= '0;
  endtask : bus
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic rv(input string nm, input logic [3:0] a, input logic [31:0] x);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(nm, q, x);
  endtask : rv
  // stop the timer before any count write, since an increment racing a write is lost
  task automatic meas(input logic [31:0] c, output logic [31:0] q);
    wr(4'h8, 32'h0);
    wr(4'h0, 32'h0);
    wr(4'h4, 32'h0);
    wr(4'h8, c);
    repeat (61) @(posedge clk_i);
    wr(4'h8, 32'h0);
    bus(1'b0, 4'h0, 32'h0, q);
  endtask : meas
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rv("low", 4'h0, 32'h0);
    rv("high", 4'h4, 32'h0);
    rv("ctrl", 4'h8, 32'h0);
    rv("stat", 4'hC, 32'h0);
    bus(1'b0, 4'h2, 32'h0, v);
    wr(4'h0, 32'h34);
    wr(4'h4, 32'h12);
    rv("low", 4'h0, 32'h34);
    rv("high", 4'h4, 32'h12);
    wr(4'h8, 32'h8);
    wr(4'h4, 32'hAB);
    rv("buf", 4'h4, 32'hAB);
    wr(4'h0, 32'hCD);
    wr(4'h8, 32'h0);
    rv("high", 4'h4, 32'hAB);
    rv("low", 4'h0, 32'hCD);
    wr(4'h4, 32'h77);
    wr(4'h8, 32'h8);
    rv("buf", 4'h4, 32'hAB);
    rv("low", 4'h0, 32'hCD);
    rv("snap", 4'h4, 32'h77);
    for (int s = 0; s < 2; s++) begin
      for (int p = 0; p < 4; p++) begin
        meas(32'(12'h001 | (s << 5) | (p << 7)), v);
        e = (s == 1 ? 64 : 16) >> p;
        chk("rate", near(v, e), 32'(e));
      end
    end
    for (int p = 0; p < 2; p++) begin
      for (int g = 0; g < 2; g++) begin
        gl <= g[0];
        meas(32'(12'h023 | (p << 2)), v);
        e = (p == g) ? 64 : 0;
        chk("gate", near(v, e), 32'(e));
      end
    end
    meas(32'h22, v);
    chk("off", v, 32'h0);
    meas(32'h61, v);
    chk("nosrc", v, 32'h0);
    for (int b = 0; b < 2; b++) begin
      for (int sl = 0; sl < 2; sl++) begin
        wr(4'h0, 32'h0);
        wr(4'h8, 32'(12'h041 | (b << 4)));
        slp <= sl[0];
        np <= 8'h05;
        go <= 1'b1;
        @(posedge clk_i);
        go <= 1'b0;
        do @(posedge clk_i); while (busy === 1'b1);
        repeat (4) @(posedge clk_i);
        slp <= 1'b0;
        wr(4'h8, 32'h0);
        rv("pin", 4'h0, (sl == 1 && b == 0) ? 32'h0 : 32'h4);
      end
    end
    wr(4'h4, 32'hFF);
    wr(4'h0, 32'hFE);
    wr(4'h8, 32'h21);
    repeat (8) @(posedge clk_i);
    wr(4'h8, 32'h0);
    chk("ovf", 32'(ovf), 32'h1);
    rv("stat", 4'hC, 32'h1);
    wr(4'hC, 32'h1);
    rv("stat", 4'hC, 32'h0);
    summarize();
  end
endmodule : tb_top
